// ---- bmx_pkg.sv ----
// Shared constants, types and view functions for the byte move executor
package bmx_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int NUM_REGS   = 8;
    localparam int REG_W      = 32;
    localparam int HALF_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int RIDX_W     = 3;
    localparam int VIDX_W     = 4;
    localparam int BUS_AW     = 8;
    localparam int EXT_W      = 24;
    localparam int CNT_W      = 4;
    localparam int LEN_W      = 4;

    // ****************************************************************
    // Flag register layout
    // ****************************************************************
    localparam int FLAG_C     = 0;
    localparam int FLAG_V     = 1;
    localparam int FLAG_Z     = 2;
    localparam int FLAG_N     = 3;
    localparam int FLAG_H     = 5;
    localparam logic [7:0] FLAG_RESET = 8'h00;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [BUS_AW-1:0] ADDR_GPR_BASE  = 8'h00;
    localparam logic [BUS_AW-1:0] ADDR_FLAGS     = 8'h20;
    localparam logic [BUS_AW-1:0] ADDR_STATUS    = 8'h24;
    localparam logic [BUS_AW-1:0] ADDR_HALF_BASE = 8'h40;
    localparam logic [BUS_AW-1:0] ADDR_BYTE_BASE = 8'h80;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_LEN  = 4;

    // ****************************************************************
    // Addressing modes of the byte transfer group
    // ****************************************************************
    typedef enum logic [3:0] {
        MODE_IMM,
        MODE_REG,
        MODE_IND_LD,
        MODE_D16_LD,
        MODE_D24_LD,
        MODE_POSTINC_LD,
        MODE_ABS8_LD,
        MODE_ABS16_LD,
        MODE_ABS24_LD,
        MODE_IND_ST
    } bmx_mode_t;

    // State counts per mode, one state per clock
    localparam logic [CNT_W-1:0] ST_IMM   = 4'h2;
    localparam logic [CNT_W-1:0] ST_REG   = 4'h2;
    localparam logic [CNT_W-1:0] ST_IND   = 4'h4;
    localparam logic [CNT_W-1:0] ST_D16   = 4'h6;
    localparam logic [CNT_W-1:0] ST_D24   = 4'hA;
    localparam logic [CNT_W-1:0] ST_POST  = 4'h6;
    localparam logic [CNT_W-1:0] ST_ABS8  = 4'h4;
    localparam logic [CNT_W-1:0] ST_ABS16 = 4'h6;
    localparam logic [CNT_W-1:0] ST_ABS24 = 4'h8;
    localparam logic [CNT_W-1:0] ST_ST    = 4'h4;

    // Encoding lengths in bytes
    localparam logic [LEN_W-1:0] LEN_2 = 4'h2;
    localparam logic [LEN_W-1:0] LEN_4 = 4'h4;
    localparam logic [LEN_W-1:0] LEN_6 = 4'h6;
    localparam logic [LEN_W-1:0] LEN_8 = 4'h8;

    localparam logic [REG_W-1:0] POSTINC_STEP = 32'h0000_0001;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        bmx_mode_t          mode;
        logic [VIDX_W-1:0]  dst;   // byte view, or address reg for stores
        logic [VIDX_W-1:0]  src;   // byte view, or address reg for loads
        logic [EXT_W-1:0]   ext;   // displacement or absolute address
        logic [BYTE_W-1:0]  imm;
    } bmx_instr_t;

    typedef struct packed {
        logic [REG_W-1:0]   addr;
        logic [BYTE_W-1:0]  wdata;
        logic               rd;
        logic               wr;
    } bmx_mem_req_t;

    typedef logic [NUM_REGS-1:0][REG_W-1:0] bmx_regs_t;

    // ****************************************************************
    // Views of the register file
    // ****************************************************************
    // Byte view: 0..7 high byte of the low half, 8..15 low byte
    function automatic logic [BYTE_W-1:0] bmx_byte_view(bmx_regs_t r, logic [VIDX_W-1:0] i);
        logic [REG_W-1:0] w;
        w = r[i[RIDX_W-1:0]];
        return i[VIDX_W-1] ? w[BYTE_W-1:0] : w[HALF_W-1:BYTE_W];
    endfunction : bmx_byte_view

    // Half view: 0..7 low halves, 8..15 extended halves
    function automatic logic [HALF_W-1:0] bmx_half_view(bmx_regs_t r, logic [VIDX_W-1:0] i);
        logic [REG_W-1:0] w;
        w = r[i[RIDX_W-1:0]];
        return i[VIDX_W-1] ? w[REG_W-1:HALF_W] : w[HALF_W-1:0];
    endfunction : bmx_half_view

    function automatic logic [CNT_W-1:0] bmx_states(bmx_mode_t m);
        case (m)
            MODE_IMM:        return ST_IMM;
            MODE_REG:        return ST_REG;
            MODE_IND_LD:     return ST_IND;
            MODE_D16_LD:     return ST_D16;
            MODE_D24_LD:     return ST_D24;
            MODE_POSTINC_LD: return ST_POST;
            MODE_ABS8_LD:    return ST_ABS8;
            MODE_ABS16_LD:   return ST_ABS16;
            MODE_ABS24_LD:   return ST_ABS24;
            MODE_IND_ST:     return ST_ST;
            default:         return ST_REG;
        endcase
    endfunction : bmx_states

    function automatic logic [LEN_W-1:0] bmx_length(bmx_mode_t m);
        case (m)
            MODE_D16_LD,
            MODE_ABS16_LD:   return LEN_4;
            MODE_D24_LD:     return LEN_8;
            MODE_ABS24_LD:   return LEN_6;
            default:         return LEN_2;
        endcase
    endfunction : bmx_length

endpackage : bmx_pkg

// ---- bmx_regfile.sv ----
// General register file: eight 32-bit registers with byte and word write ports
`timescale 1ns/1ps
`default_nettype none

module bmx_regfile
    import bmx_pkg::*;
#(
    parameter int N = bmx_pkg::NUM_REGS
)
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    // Whole-register write
    input  wire logic                       word_we,
    input  wire logic [bmx_pkg::RIDX_W-1:0] word_idx,
    input  wire logic [bmx_pkg::REG_W-1:0]  word_wdata,
    // Byte view write, applied over the word write
    input  wire logic                       byte_we,
    input  wire logic [bmx_pkg::VIDX_W-1:0] byte_idx,
    input  wire logic [bmx_pkg::BYTE_W-1:0] byte_wdata,
    // Contents
    output bmx_pkg::bmx_regs_t              regs
);
    import bmx_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_reg
            logic [REG_W-1:0] next_val;

            always_comb
            begin
                next_val = regs[g];
                if (word_we && word_idx == RIDX_W'(g))
                    next_val = word_wdata;
                // Byte lands last so a load into the address register wins
                if (byte_we && byte_idx[RIDX_W-1:0] == RIDX_W'(g))
                begin
                    if (byte_idx[VIDX_W-1])
                        next_val[BYTE_W-1:0] = byte_wdata;
                    else
                        next_val[HALF_W-1:BYTE_W] = byte_wdata;
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    regs[g] <= '0;
                else
                    regs[g] <= next_val;  // [RQ1]
            end
        end
    endgenerate

endmodule : bmx_regfile

`default_nettype wire

// ---- bmx_exec.sv ----
// Byte transfer instruction executor with register file and software port
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Registers seen as eight 32-bit, sixteen 16-bit halves, sixteen bytes.
// RQ2: Source copied to destination; source kept except address-register update.
// RQ3: Byte move sets N and Z from byte, clears V, keeps H and C.
// RQ4: Register-to-register byte move: 2 bytes, 2 states.
// RQ5: Load at address register plus sign-extended 16-bit displacement: 4 bytes, 6 states.
// RQ6: Load at address register plus 24-bit displacement: 8 bytes, 10 states.
// RQ7: Post-increment load reads byte then adds one to address register: 2 bytes, 6 states.
// RQ8: Indirect store writes source byte at address register: 2 bytes, 4 states.
// RQ9: Absolute loads with 8, 16, 24-bit address: 2/4/6 bytes, 4/6/8 states.
module bmx_exec
    import bmx_pkg::*;
#(
    parameter logic [bmx_pkg::REG_W-1:0] ABS8_BASE = 32'h0000_FF00
)
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    // Instruction issue
    input  wire logic                        instr_valid,
    input  wire bmx_pkg::bmx_instr_t         instr,
    output logic                             instr_ready,
    output logic                             instr_done,
    output logic [bmx_pkg::LEN_W-1:0]        instr_len,
    // Data memory
    output bmx_pkg::bmx_mem_req_t            mem_req,
    input  wire logic [bmx_pkg::BYTE_W-1:0]  mem_rdata,
    // Software register port
    input  wire logic [bmx_pkg::BUS_AW-1:0]  reg_addr,
    input  wire logic [bmx_pkg::REG_W-1:0]   reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [bmx_pkg::REG_W-1:0]        reg_rdata,
    // Flags
    output logic [7:0]                       flag_register
);
    import bmx_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} bmx_state_t;

    bmx_state_t         state;
    bmx_instr_t         op;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   last_cnt;
    logic [BYTE_W-1:0]  load_data;
    logic               load_pend;
    bmx_regs_t          regs;
    logic               accept;
    logic               finish;
    logic [REG_W-1:0]   next_addr;
    logic [BYTE_W-1:0]  result;
    logic               word_we;
    logic [RIDX_W-1:0]  word_idx;
    logic [REG_W-1:0]   word_wdata;
    logic               byte_we;
    logic [VIDX_W-1:0]  byte_idx;
    logic [BYTE_W-1:0]  byte_wdata;
    logic               sw_gpr_hit;

    function automatic logic mode_loads(bmx_mode_t m);
        case (m)
            MODE_IND_LD, MODE_D16_LD, MODE_D24_LD, MODE_POSTINC_LD,
            MODE_ABS8_LD, MODE_ABS16_LD, MODE_ABS24_LD: return 1'b1;
            default:                                    return 1'b0;
        endcase
    endfunction : mode_loads

    assign accept      = (state == ST_IDLE) && instr_valid;
    assign instr_ready = (state == ST_IDLE);
    assign finish      = (state == ST_RUN) && (cnt == last_cnt);
    assign instr_done  = finish;

    // ****************************************************************
    // Effective address of the incoming instruction
    // ****************************************************************
    always_comb
    begin
        case (instr.mode)
            MODE_IND_LD, MODE_POSTINC_LD:
                next_addr = regs[instr.src[RIDX_W-1:0]];  // [RQ7]
            MODE_D16_LD:
                next_addr = regs[instr.src[RIDX_W-1:0]]
                          + {{(REG_W-HALF_W){instr.ext[HALF_W-1]}}, instr.ext[HALF_W-1:0]};  // [RQ5]
            MODE_D24_LD:
                next_addr = regs[instr.src[RIDX_W-1:0]]
                          + {{(REG_W-EXT_W){instr.ext[EXT_W-1]}}, instr.ext};  // [RQ6]
            MODE_ABS8_LD:
                next_addr = ABS8_BASE | {{(REG_W-BYTE_W){1'b0}}, instr.ext[BYTE_W-1:0]};  // [RQ9]
            MODE_ABS16_LD:
                next_addr = {{(REG_W-HALF_W){instr.ext[HALF_W-1]}}, instr.ext[HALF_W-1:0]};  // [RQ9]
            MODE_ABS24_LD:
                next_addr = {{(REG_W-EXT_W){1'b0}}, instr.ext};  // [RQ9]
            MODE_IND_ST:
                next_addr = regs[instr.dst[RIDX_W-1:0]];  // [RQ8]
            default:
                next_addr = '0;
        endcase
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state    <= ST_IDLE;
            cnt      <= '0;
            last_cnt <= '0;
            op       <= '0;
        end
        else if (accept)
        begin
            state    <= ST_RUN;
            cnt      <= CNT_W'(1);
            // Issue cycle is the first state; one busy cycle per remaining state
            last_cnt <= bmx_states(instr.mode) - CNT_W'(1);  // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
            op       <= instr;
        end
        else if (finish)
        begin
            state <= ST_IDLE;
            cnt   <= '0;
        end
        else if (state == ST_RUN)
            cnt <= cnt + CNT_W'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            instr_len <= LEN_2;
        else if (accept)
            instr_len <= bmx_length(instr.mode);  // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
    end

    // ****************************************************************
    // Memory access
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            mem_req <= '0;
        else
        begin
            mem_req.rd <= accept && mode_loads(instr.mode);
            mem_req.wr <= accept && (instr.mode == MODE_IND_ST);  // [RQ8]
            if (accept)
            begin
                mem_req.addr  <= next_addr;
                mem_req.wdata <= bmx_byte_view(regs, instr.src);  // [RQ2]
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            load_pend <= 1'b0;
            load_data <= '0;
        end
        else
        begin
            load_pend <= mem_req.rd;
            if (load_pend)
                load_data <= mem_rdata;
        end
    end

    // ****************************************************************
    // Write-back
    // ****************************************************************
    always_comb
    begin
        case (op.mode)
            MODE_IMM:    result = op.imm;
            MODE_REG,
            MODE_IND_ST: result = bmx_byte_view(regs, op.src);  // [RQ4]
            default:     result = load_data;
        endcase
    end

    // Software writes only land while idle, so they never race write-back
    assign sw_gpr_hit = reg_wr && (state == ST_IDLE) && (reg_addr < ADDR_FLAGS)
                        && (reg_addr[1:0] == 2'b00);

    always_comb
    begin
        byte_we    = finish && (op.mode != MODE_IND_ST);  // [RQ2]
        byte_idx   = op.dst;
        byte_wdata = result;
        word_we    = sw_gpr_hit;
        word_idx   = reg_addr[RIDX_W+1:2];
        word_wdata = reg_wdata;
        if (finish && op.mode == MODE_POSTINC_LD)
        begin
            word_we    = 1'b1;
            word_idx   = op.src[RIDX_W-1:0];
            word_wdata = regs[op.src[RIDX_W-1:0]] + POSTINC_STEP;  // [RQ7]
        end
    end

    bmx_regfile #(
        .N (NUM_REGS)
    ) u_regfile (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .word_we    (word_we),
        .word_idx   (word_idx),
        .word_wdata (word_wdata),
        .byte_we    (byte_we),
        .byte_idx   (byte_idx),
        .byte_wdata (byte_wdata),
        .regs       (regs)
    );

    // ****************************************************************
    // Flags
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            flag_register <= FLAG_RESET;
        else if (finish)
        begin
            flag_register[FLAG_N] <= result[BYTE_W-1];  // [RQ3]
            flag_register[FLAG_Z] <= (result == '0);    // [RQ3]
            flag_register[FLAG_V] <= 1'b0;              // [RQ3]
        end
        else if (reg_wr && state == ST_IDLE && reg_addr == ADDR_FLAGS)
            flag_register <= reg_wdata[7:0];
    end

    // ****************************************************************
    // Software read port
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            reg_rdata <= '0;
            if (reg_addr < ADDR_FLAGS && reg_addr[1:0] == 2'b00)
                reg_rdata <= regs[reg_addr[RIDX_W+1:2]];  // [RQ1]
            else if (reg_addr == ADDR_FLAGS)
                reg_rdata <= {{(REG_W-8){1'b0}}, flag_register};
            else if (reg_addr == ADDR_STATUS)
            begin
                reg_rdata[STATUS_BUSY] <= (state == ST_RUN);
                reg_rdata[STATUS_LEN +: LEN_W] <= instr_len;
            end
            else if (reg_addr >= ADDR_HALF_BASE && reg_addr < ADDR_BYTE_BASE
                     && reg_addr[1:0] == 2'b00)
                reg_rdata <= {{(REG_W-HALF_W){1'b0}},
                              bmx_half_view(regs, reg_addr[VIDX_W+1:2])};  // [RQ1]
            else if (reg_addr >= ADDR_BYTE_BASE && reg_addr[6] == 1'b0
                     && reg_addr[1:0] == 2'b00)
                reg_rdata <= {{(REG_W-BYTE_W){1'b0}},
                              bmx_byte_view(regs, reg_addr[VIDX_W+1:2])};  // [RQ1]
        end
    end

endmodule : bmx_exec

`default_nettype wire

// ---- bmx_exec_checker.sv ----
// Port-level assertions for the byte move executor
`timescale 1ns/1ps
`default_nettype none

module bmx_exec_checker
    import bmx_pkg::*;
#(
    parameter logic [bmx_pkg::REG_W-1:0] ABS8_BASE = 32'h0000_FF00
)
(
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       srst,
    // Instruction issue
    input wire logic                       instr_valid,
    input wire bmx_pkg::bmx_instr_t        instr,
    input wire logic                       instr_ready,
    input wire logic                       instr_done,
    input wire logic [bmx_pkg::LEN_W-1:0]  instr_len,
    // Memory and flags
    input wire bmx_pkg::bmx_mem_req_t      mem_req,
    input wire logic [7:0]                 flag_register
);
    // ****************************************************************
    // Helpers and sequences
    // ****************************************************************
    logic       acc;
    localparam logic [3:0] LEN_TAB [10] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h8,
        4'h2, 4'h2, 4'h4, 4'h6, 4'h2};

    assign acc = instr_valid && instr_ready;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_wait4_done;
        (!instr_ready && !instr_done) [*4] ##1 instr_done;
    endsequence
    sequence s_wait8_done;
        (!instr_ready && !instr_done) [*8] ##1 (instr_done && !instr_ready);
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_REG_TWO: assert property (acc && instr.mode == MODE_REG |=>
        instr_done && !mem_req.rd && !mem_req.wr)
        else $error("reg move");
    AST_D16_SIX: assert property (acc && instr.mode == MODE_D16_LD |=>
        mem_req.rd ##0 s_wait4_done)
        else $error("d16 load");
    AST_D24_TEN: assert property (acc && instr.mode == MODE_D24_LD |=>
        s_wait8_done)
        else $error("d24 load");
    AST_POST_SIX: assert property (acc && instr.mode == MODE_POSTINC_LD |=>
        mem_req.rd ##0 s_wait4_done)
        else $error("postinc load");
    AST_STORE: assert property (acc && instr.mode == MODE_IND_ST |=>
        mem_req.wr && !mem_req.rd ##1 !mem_req.wr ##1 instr_done)
        else $error("store");
    AST_ABS8: assert property (acc && instr.mode == MODE_ABS8_LD |=>
        mem_req.rd && mem_req.addr == (ABS8_BASE | {24'h0, $past(instr.ext[7:0])})
        ##2 instr_done)
        else $error("abs8 load");
    AST_ABS24: assert property (acc && instr.mode == MODE_ABS24_LD |=>
        mem_req.rd && mem_req.addr == {8'h00, $past(instr.ext)} ##6 instr_done)
        else $error("abs24 load");
    AST_LEN: assert property (acc |=> instr_len == $past(LEN_TAB[instr.mode]))
        else $error("length");
    AST_FLAGS_KEPT: assert property (instr_done |=> !flag_register[FLAG_V] &&
        flag_register[FLAG_H] == $past(flag_register[FLAG_H]) &&
        flag_register[FLAG_C] == $past(flag_register[FLAG_C]))
        else $error("V, H or C");
    AST_IMM_NZ: assert property (acc && instr.mode == MODE_IMM |=> instr_done ##1
        flag_register[FLAG_Z] == ($past(instr.imm, 2) == 8'h00) &&
        flag_register[FLAG_N] == $past(instr.imm[7], 2))
        else $error("N or Z");
endmodule : bmx_exec_checker

bind bmx_exec bmx_exec_checker #(.ABS8_BASE(ABS8_BASE)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .instr_done(instr_done), .instr_len(instr_len),
    .mem_req(mem_req), .flag_register(flag_register));

`default_nettype wire

// ---- bmx_mem_model.sv ----
// Behavioural data memory for the executor
`timescale 1ns/1ps
`default_nettype none

module bmx_mem_model
    import bmx_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // Memory port
    input  wire bmx_pkg::bmx_mem_req_t  mem_req,
    output logic [bmx_pkg::BYTE_W-1:0]  mem_rdata
);
    logic [7:0] mem [logic [31:0]];

    // Unwritten bytes read as an address hash
    function automatic logic [7:0] peek(logic [31:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3C;
    endfunction : peek

    // Toggles unless read, so late samples show
    always @(posedge sys_clk)
    begin
        if (srst)
            mem_rdata <= 8'h00;
        else if (mem_req.rd)
            mem_rdata <= peek(mem_req.addr);
        else
            mem_rdata <= ~mem_rdata;
        if (mem_req.wr)
            mem[mem_req.addr] = mem_req.wdata;
    end
endmodule : bmx_mem_model

`default_nettype wire

// ---- bmx_exec_tb_top.sv ----
// Self-checking bench for the byte move executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module bmx_exec_tb_top;
    import bmx_pkg::*;
    localparam logic [31:0] ABS8 = 32'h0000_FF00;
    logic         sys_clk = 1'b0;
    logic         srst = 1'b1;
    logic         instr_valid = 1'b0;
    bmx_instr_t   instr = '0;
    logic         instr_ready, instr_done;
    logic [3:0]   instr_len;
    bmx_mem_req_t mem_req;
    logic [7:0]   mem_rdata, flag_register, shf;
    logic [7:0]   reg_addr = '0;
    logic [31:0]  reg_wdata = '0, reg_rdata;
    logic         reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0]  sh [8];
    int           miscompares = 0, n_tests = 0, tno = 0;
    logic [3:0]   st_tab [10] = '{4'h2, 4'h2, 4'h4, 4'h6, 4'hA, 4'h6, 4'h4, 4'h6, 4'h8, 4'h4};
    logic [3:0]   ln_tab [10] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h8, 4'h2, 4'h2, 4'h4, 4'h6, 4'h2};

    always #5 sys_clk = ~sys_clk;

    bmx_exec #(.ABS8_BASE(ABS8)) dut (.sys_clk(sys_clk), .srst(srst),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .instr_done(instr_done), .instr_len(instr_len), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flag_register(flag_register));
    bmx_mem_model u_mem (.sys_clk(sys_clk), .srst(srst), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    // ****************************************************************
    // Bus tasks and shadow model
    // ****************************************************************
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    function automatic logic [7:0] bget(logic [3:0] i);
        return i[3] ? sh[i[2:0]][7:0] : sh[i[2:0]][15:8];
    endfunction : bget

    task automatic check_all();
        logic [31:0] r;
        int i;
        for (int n = 0; n < 8; n++)
        begin
            rd(ADDR_GPR_BASE + 8'(n * 4), r);
            `CHK("gpr", sh[n], r)
        end
        rd(ADDR_FLAGS, r);
        `CHK("flags", shf, r[7:0])
        i = $urandom_range(0, 15);
        rd(ADDR_HALF_BASE + 8'(i * 4), r);
        `CHK("half", (i > 7 ? sh[i - 8][31:16] : sh[i][15:0]), r[15:0])
        rd(ADDR_BYTE_BASE + 8'(i * 4), r);
        `CHK("byte", bget(4'(i)), r[7:0])
    endtask : check_all

    task automatic run(input bmx_mode_t m, input logic [3:0] d, input logic [3:0] s,
                       input logic [23:0] x, input logic [7:0] im);
        logic [31:0] a, ar;
        logic [7:0] v;
        int k;
        ar = sh[s[2:0]];
        case (m)
            MODE_D16_LD:   a = ar + {{16{x[15]}}, x[15:0]};
            MODE_D24_LD:   a = ar + {{8{x[23]}}, x};
            MODE_ABS8_LD:  a = ABS8 | {24'h0, x[7:0]};
            MODE_ABS16_LD: a = {{16{x[15]}}, x[15:0]};
            MODE_ABS24_LD: a = {8'h00, x};
            MODE_IND_ST:   a = sh[d[2:0]];
            default:       a = ar;
        endcase
        v = (m == MODE_IMM) ? im
          : (m == MODE_REG || m == MODE_IND_ST) ? bget(s) : u_mem.peek(a);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= '{m, d, s, x, im};
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
        for (k = 1; instr_done !== 1'b1 && k < 20; k++)
            @(negedge sys_clk);
        `CHK("states", st_tab[m], 4'(k + 1))
        @(posedge sys_clk);
        #1;
        `CHK("length", ln_tab[m], instr_len)
        if (m == MODE_POSTINC_LD)
            sh[s[2:0]] = ar + 32'h1;
        if (m == MODE_IND_ST)
            `CHK("stored", v, u_mem.peek(a))
        else
            sh[d[2:0]][(d[3] ? 0 : 8) +: 8] = v;
        shf = {shf[7:4], v[7], v == 8'h00, 1'b0, shf[0]};
        check_all();
        tno++;
        $display("test %0d %s done", tno, m.name());
    endtask : run

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        logic [31:0] r;
        r = $urandom(32'h76E15BE1);
        shf = 8'h00;
        sh = '{default: '0};
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        check_all();
        rd(ADDR_STATUS, r);
        `CHK("reset len", 4'h2, r[7:4])
        rd(8'h30, r);
        `CHK("unmapped", 32'h0, r)
        for (int n = 0; n < 8; n++)
        begin
            sh[n] = $urandom;
            wr(ADDR_GPR_BASE + 8'(n * 4), sh[n]);
        end
        shf = 8'($urandom) | 8'h21;
        wr(ADDR_FLAGS, {24'h0, shf});
        // Zero, sign bit, negative offsets, increment overlap
        run(MODE_IMM, 4'h9, 4'h0, 24'h0, 8'h00);
        run(MODE_IMM, 4'h2, 4'h0, 24'h0, 8'h80);
        run(MODE_D16_LD, 4'hA, 4'h3, 24'h00FFFE, 8'h0);
        run(MODE_D24_LD, 4'h1, 4'h4, 24'h800000, 8'h0);
        run(MODE_POSTINC_LD, 4'hD, 4'h5, 24'h0, 8'h0);
        run(MODE_IND_ST, 4'h6, 4'hB, 24'h0, 8'h0);
        run(MODE_IND_LD, 4'hF, 4'h6, 24'h0, 8'h0);
        run(MODE_ABS8_LD, 4'h0, 4'h0, 24'h0000FF, 8'h0);
        run(MODE_ABS16_LD, 4'h8, 4'h0, 24'h008000, 8'h0);
        run(MODE_ABS24_LD, 4'h7, 4'h0, 24'hFFFFFF, 8'h0);
        run(MODE_REG, 4'hC, 4'h4, 24'h0, 8'h0);
        for (int t = 0; t < 30; t++)
            run(bmx_mode_t'($urandom_range(0, 9)), 4'($urandom), 4'($urandom),
                24'($urandom), 8'($urandom));
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end
endmodule : bmx_exec_tb_top

`undef CHK
`default_nettype wire
